// file: verilog/dbgcp0_defs.svh
// constants of the debug/error coprocessor register block
`ifndef DBGCP0_DEFS_SVH
`define DBGCP0_DEFS_SVH

// ----------------------------------------
// coprocessor register numbers
// ----------------------------------------
`define DBGCP0_SEL_STATUS 5'h0C
`define DBGCP0_SEL_DCAUSE 5'h17
`define DBGCP0_SEL_DEBUG_RETURN_PC 5'h18
`define DBGCP0_SEL_CACHE_TAG_LOW 5'h1C
`define DBGCP0_SEL_CACHE_TAG_HIGH 5'h1D
`define DBGCP0_SEL_EEPC 5'h1E
`define DBGCP0_SEL_SCRATCH 5'h1F

// ----------------------------------------
// field positions
// ----------------------------------------
`define DBGCP0_DCAUSE_DBD 31
`define DBGCP0_DCAUSE_DM 30
`define DBGCP0_STATUS_BEV 22
`define DBGCP0_STATUS_SR 20
`define DBGCP0_STATUS_ERL 2
`define DBGCP0_CACHE_TAG_HIGH_WAY 31
`define DBGCP0_CACHE_TAG_LOW_LOCK 2
`define DBGCP0_CACHE_TAG_LOW_WAY 1

// ----------------------------------------
// writable masks and reset values
// ----------------------------------------
`define DBGCP0_CACHE_TAG_LOW_MASK 64'h0000_0000_FFFF_FFFE
`define DBGCP0_CACHE_TAG_HIGH_MASK 64'h0000_0000_C000_0000
`define DBGCP0_FULL_MASK 64'hFFFF_FFFF_FFFF_FFFF
`define DBGCP0_ZERO64 64'h0000_0000_0000_0000
`define DBGCP0_STATUS_COLD 3'h5
`define DBGCP0_STATUS_WARM 3'h7
`define DBGCP0_STATE_VALID 2'h3
`define DBGCP0_STATE_INVALID 2'h0

`endif

// file: verilog/dbgcp0_pkg.sv
// types shared by the debug/error coprocessor register block
package dbgcp0_pkg;

    // one-hot debug exception kind, bit order matches the cause field
    typedef enum logic [5:0] {
        DBGCP0_K_STEP = 6'h01,
        DBGCP0_K_SWBRK = 6'h02,
        DBGCP0_K_LDBRK = 6'h04,
        DBGCP0_K_STBRK = 6'h08,
        DBGCP0_K_IBRK = 6'h10,
        DBGCP0_K_IRQ = 6'h20
    } dbgcp0_kind_t;

    // tag words delivered by the cache maintenance instruction
    typedef struct packed {
        logic [31:0] hi;
        logic [31:0] lo;
    } dbgcp0_tagin_t;

    // decoded staging-tag fields handed to the cache
    typedef struct packed {
        logic [23:0] paddr_hi;
        logic paddr_bit11;
        logic [1:0] line_state;
        logic lock;
        logic [1:0] way_sel;
    } dbgcp0_tagf_t;

    // status bits forced by warm reset
    typedef struct packed {
        logic boot_vector_sel;
        logic soft_reset_flag;
        logic error_level;
    } dbgcp0_stat_t;

endpackage

// file: verilog/dbgcp0_mreg.sv
// masked register with software write and hardware load
`timescale 1ns/1ps
`include "dbgcp0_defs.svh"
module dbgcp0_mreg #(
    parameter logic [63:0] MASK = `DBGCP0_FULL_MASK
) (
    input wire logic mclk, // core clock
    input wire logic reset_n, // cold reset, active low
    input wire logic sw_we, // coprocessor move write
    input wire logic [63:0] sw_data, // move data
    input wire logic hw_we, // hardware capture
    input wire logic [63:0] hw_data, // captured value
    output logic [63:0] q // register value
);
    // hardware capture beats a colliding move; masked bits stay zero
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            q <= `DBGCP0_ZERO64;
        end else if (hw_we) begin
            q <= hw_data & MASK;
        end else if (sw_we) begin
            q <= sw_data & MASK;
        end
    end
endmodule // dbgcp0_mreg

// file: verilog/dbgcp0_regs.sv
// debug, error-return and cache-tag coprocessor registers
`timescale 1ns/1ps
`include "dbgcp0_defs.svh"
module dbgcp0_regs (
    input wire logic mclk, // core clock
    input wire logic reset_n, // cold reset, active low
    input wire logic mode64, // 64-bit addressing mode
    input wire logic warm_reset, // warm reset exception pulse
    input wire logic nmi_take, // nmi exception pulse
    input wire logic dbg_take, // debug exception pulse
    input wire dbgcp0_pkg::dbgcp0_kind_t dbg_kind, // exception kind
    input wire logic in_delay_slot, // faulting instr in delay slot
    input wire logic [63:0] exc_pc, // faulting instruction address
    input wire logic [63:0] branch_pc, // preceding branch address
    input wire logic debug_return_instr, // debug return pulse
    input wire logic coproc_move_write, // move-to write strobe
    input wire logic [4:0] cp_wsel, // written register number
    input wire logic [63:0] cp_wdata, // write data
    input wire logic cp_re, // move-from read strobe
    input wire logic [4:0] cp_rsel, // read register number
    input wire logic cache_tag_we, // cache op tag load
    input wire dbgcp0_pkg::dbgcp0_tagin_t cache_tag_in, // tag words
    output logic [63:0] cp_rdata, // read data, next cycle
    output logic redirect_valid, // fetch redirect pulse
    output logic [63:0] redirect_pc, // redirect target
    output logic debug_active, // debug handler running
    output dbgcp0_pkg::dbgcp0_tagf_t tag_fields, // staging tag fields
    output dbgcp0_pkg::dbgcp0_stat_t status_bits // forced status bits
);
    // ----------------------------------------
    // internal state
    // ----------------------------------------
    logic [63:0] debug_return_pc_q;
    logic [63:0] eepc_q;
    logic [63:0] scratch_q;
    logic [63:0] cache_tag_low_q;
    logic [63:0] cache_tag_high_q;
    logic [5:0] cause_reg;
    logic dbd_reg;
    logic dm_reg;
    logic cold_pend_reg;
    logic take_ok;
    logic [63:0] dbg_pc;
    logic [63:0] cp_rdata_next;
    logic [63:0] tag_lo_in;
    logic [63:0] tag_hi_in;
    logic [63:0] wdata_fix;

    // 32-bit mode keeps addresses sign-extended from bit 31
    function automatic logic [63:0] fix_pc(input logic [63:0] v,
                                           input logic m64);
        fix_pc = m64 ? v : {{32{v[31]}}, v[31:0]};
    endfunction

    // debug exceptions are masked while the handler runs
    assign take_ok = dbg_take & ~dm_reg;

    // ----------------------------------------
    // debug pc capture
    // ----------------------------------------
    // delay slot returns to the branch so it is re-executed
    assign dbg_pc = fix_pc(in_delay_slot ? branch_pc : exc_pc,
                           mode64);
    assign wdata_fix = fix_pc(cp_wdata, mode64);

    dbgcp0_mreg #(.MASK(`DBGCP0_FULL_MASK)) u_debug_return_pc (
        .mclk(mclk),
        .reset_n(reset_n),
        .sw_we(coproc_move_write && cp_wsel == `DBGCP0_SEL_DEBUG_RETURN_PC),
        .sw_data(wdata_fix),
        .hw_we(take_ok),
        .hw_data(dbg_pc),
        .q(debug_return_pc_q)
    );

    // ----------------------------------------
    // error pc: cold reset, warm reset, nmi
    // ----------------------------------------
    // pc cannot be sampled under async reset, so take it at release
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cold_pend_reg <= 1'b1;
        end else begin
            cold_pend_reg <= 1'b0;
        end
    end

    // delay slot resumes at the branch; no slot flag is kept
    dbgcp0_mreg #(.MASK(`DBGCP0_FULL_MASK)) u_eepc (
        .mclk(mclk),
        .reset_n(reset_n),
        .sw_we(coproc_move_write && cp_wsel == `DBGCP0_SEL_EEPC),
        .sw_data(wdata_fix),
        .hw_we(cold_pend_reg | warm_reset | nmi_take),
        .hw_data(dbg_pc),
        .q(eepc_q)
    );

    // ----------------------------------------
    // debug scratch
    // ----------------------------------------
    dbgcp0_mreg #(.MASK(`DBGCP0_FULL_MASK)) u_scratch (
        .mclk(mclk),
        .reset_n(reset_n),
        .sw_we(coproc_move_write && cp_wsel == `DBGCP0_SEL_SCRATCH),
        .sw_data(cp_wdata),
        .hw_we(1'b0),
        .hw_data(`DBGCP0_ZERO64),
        .q(scratch_q)
    );

    // ----------------------------------------
    // cache tag staging
    // ----------------------------------------
    assign tag_lo_in = {32'h0000_0000, cache_tag_in.lo};
    assign tag_hi_in = {32'h0000_0000, cache_tag_in.hi};

    // cache op wins a same-cycle collision with a move
    dbgcp0_mreg #(.MASK(`DBGCP0_CACHE_TAG_LOW_MASK)) u_cache_tag_low (
        .mclk(mclk),
        .reset_n(reset_n),
        .sw_we(coproc_move_write && cp_wsel == `DBGCP0_SEL_CACHE_TAG_LOW),
        .sw_data(cp_wdata),
        .hw_we(cache_tag_we),
        .hw_data(tag_lo_in),
        .q(cache_tag_low_q)
    );

    dbgcp0_mreg #(.MASK(`DBGCP0_CACHE_TAG_HIGH_MASK)) u_cache_tag_high (
        .mclk(mclk),
        .reset_n(reset_n),
        .sw_we(coproc_move_write && cp_wsel == `DBGCP0_SEL_CACHE_TAG_HIGH),
        .sw_data(cp_wdata),
        .hw_we(cache_tag_we),
        .hw_data(tag_hi_in),
        .q(cache_tag_high_q)
    );

    // registered decode of the tag fields toward the cache
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            tag_fields <= '0;
        end else begin
            tag_fields.paddr_hi <= cache_tag_low_q[31:8];
            tag_fields.paddr_bit11 <= cache_tag_high_q[30];
            tag_fields.line_state <= cache_tag_low_q[7:6];
            tag_fields.lock <= cache_tag_low_q[`DBGCP0_CACHE_TAG_LOW_LOCK];
            tag_fields.way_sel <= {cache_tag_high_q[`DBGCP0_CACHE_TAG_HIGH_WAY],
                                   cache_tag_low_q[`DBGCP0_CACHE_TAG_LOW_WAY]};
        end
    end

    // ----------------------------------------
    // debug cause and mode
    // ----------------------------------------
    // cause reflects the most recent debug exception only
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cause_reg <= 6'h00;
            dbd_reg <= 1'b0;
        end else if (take_ok) begin
            cause_reg <= dbg_kind;
            dbd_reg <= in_delay_slot;
        end
    end

    // entry beats a return arriving in the same cycle
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            dm_reg <= 1'b0;
        end else if (take_ok) begin
            dm_reg <= 1'b1;
        end else if (debug_return_instr) begin
            dm_reg <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            debug_active <= 1'b0;
        end else begin
            debug_active <= take_ok | (dm_reg & ~debug_return_instr);
        end
    end

    // ----------------------------------------
    // debug return redirect
    // ----------------------------------------
    // a return outside debug mode is ignored
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            redirect_valid <= 1'b0;
            redirect_pc <= `DBGCP0_ZERO64;
        end else begin
            redirect_valid <= debug_return_instr & dm_reg;
            redirect_pc <= debug_return_pc_q;
        end
    end

    // ----------------------------------------
    // status bits forced by resets
    // ----------------------------------------
    // cold reset clears the warm flag and always outranks warm reset
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            status_bits <= `DBGCP0_STATUS_COLD;
        end else if (warm_reset) begin
            status_bits <= `DBGCP0_STATUS_WARM;
        end else if (coproc_move_write &&
                     cp_wsel == `DBGCP0_SEL_STATUS) begin
            status_bits <= {cp_wdata[`DBGCP0_STATUS_BEV],
                            cp_wdata[`DBGCP0_STATUS_SR],
                            cp_wdata[`DBGCP0_STATUS_ERL]};
        end
    end

    // ----------------------------------------
    // read path
    // ----------------------------------------
    // unmapped numbers and reserved bits read as zero
    always_comb begin
        cp_rdata_next = `DBGCP0_ZERO64;
        unique case (cp_rsel)
            `DBGCP0_SEL_STATUS: begin
                cp_rdata_next[`DBGCP0_STATUS_BEV] = status_bits[2];
                cp_rdata_next[`DBGCP0_STATUS_SR] = status_bits[1];
                cp_rdata_next[`DBGCP0_STATUS_ERL] = status_bits[0];
            end
            `DBGCP0_SEL_DCAUSE: begin
                cp_rdata_next[`DBGCP0_DCAUSE_DBD] = dbd_reg;
                cp_rdata_next[`DBGCP0_DCAUSE_DM] = dm_reg;
                cp_rdata_next[5:0] = cause_reg;
            end
            `DBGCP0_SEL_DEBUG_RETURN_PC: cp_rdata_next = debug_return_pc_q;
            `DBGCP0_SEL_CACHE_TAG_LOW: cp_rdata_next = cache_tag_low_q;
            `DBGCP0_SEL_CACHE_TAG_HIGH: cp_rdata_next = cache_tag_high_q;
            `DBGCP0_SEL_EEPC: cp_rdata_next = eepc_q;
            `DBGCP0_SEL_SCRATCH: cp_rdata_next = scratch_q;
            default: cp_rdata_next = `DBGCP0_ZERO64;
        endcase
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cp_rdata <= `DBGCP0_ZERO64;
        end else if (cp_re) begin
            cp_rdata <= cp_rdata_next;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    sequence s_entry;
        dbg_take && !dm_reg;
    endsequence

    sequence s_return;
        debug_return_instr && dm_reg && !dbg_take;
    endsequence

    a_cause_kind: assert property (s_entry |=>
        cause_reg == $past(dbg_kind))
        else $error("cause bits not loaded from kind");

    a_debug_return_pc_plain: assert property (s_entry ##0
        (!in_delay_slot && mode64) |=> debug_return_pc_q == $past(exc_pc))
        else $error("debug pc not faulting address");

    a_debug_return_pc_slot: assert property (s_entry ##0
        (in_delay_slot && mode64) |=> debug_return_pc_q == $past(branch_pc))
        else $error("debug pc not branch address");

    a_debug_return_pc_wins: assert property (s_entry ##0
        (coproc_move_write && cp_wsel == `DBGCP0_SEL_DEBUG_RETURN_PC)
        |=> debug_return_pc_q == $past(dbg_pc))
        else $error("software write beat debug capture");

    a_mode_cycle: assert property (s_entry |=>
        dm_reg && debug_active)
        else $error("debug mode not set on entry");

    a_mode_clear: assert property (s_return |=>
        !dm_reg ##0 !debug_active)
        else $error("debug mode not cleared on return");

    a_return_pc: assert property (s_return |=>
        redirect_valid && redirect_pc == $past(debug_return_pc_q) ##1
        !redirect_valid)
        else $error("return did not redirect to debug pc");

    a_warm_status: assert property (warm_reset |=>
        status_bits == `DBGCP0_STATUS_WARM)
        else $error("warm reset did not force status");

    a_eepc_nmi: assert property ((nmi_take && mode64 &&
        in_delay_slot) |=> eepc_q == $past(branch_pc))
        else $error("error pc not captured on nmi");

    a_tag_rsvd: assert property (cache_tag_low_q[0] == 1'b0 &&
        cache_tag_high_q[29:0] == 30'h0000_0000 && cache_tag_low_q[63:32] == 32'h0)
        else $error("reserved tag bits not zero");

    a_way_ptr: assert property (##1 tag_fields.way_sel ==
        {$past(cache_tag_high_q[31]), $past(cache_tag_low_q[1])})
        else $error("way pointer mismatch");

endmodule // dbgcp0_regs

// file: testbench/dbgcp0_pipe_model.sv
// pipeline-side request model for the debug/error register block
`timescale 1ns/1ps
module dbgcp0_pipe_model (
    input wire logic mclk, // core clock
    output logic mode64, // addressing mode
    output logic warm_reset, // warm reset pulse
    output logic nmi_take, // nmi pulse
    output logic dbg_take, // debug exception pulse
    output dbgcp0_pkg::dbgcp0_kind_t dbg_kind, // exception kind
    output logic in_delay_slot, // delay slot flag
    output logic [63:0] exc_pc, // faulting address
    output logic [63:0] branch_pc, // preceding branch
    output logic debug_return_instr, // debug return pulse
    output logic coproc_move_write, // move write strobe
    output logic [4:0] cp_wsel, // write number
    output logic [63:0] cp_wdata, // write data
    output logic cp_re, // read strobe
    output logic [4:0] cp_rsel, // read number
    output logic cache_tag_we, // cache op tag load
    output dbgcp0_pkg::dbgcp0_tagin_t cache_tag_in // tag words
);
    // ----------------------------------------
    // request timing
    // ----------------------------------------
    // all strobes low at start so nothing is taken in reset
    initial begin
        mode64 = 1'b1;
        {warm_reset, nmi_take, dbg_take, in_delay_slot} = 4'h0;
        {debug_return_instr, coproc_move_write} = 2'h0;
        {cp_re, cache_tag_we} = 2'h0;
        dbg_kind = dbgcp0_pkg::DBGCP0_K_STEP;
        {exc_pc, branch_pc, cp_wdata} = {3{64'h0}};
        {cp_wsel, cp_rsel} = 10'h000;
        cache_tag_in = 64'h0;
    end

    task automatic tick();
        @(posedge mclk);
        #1;
    endtask

    // strobes {warm,nmi,dbg,ret,write,read,tag} held one cycle;
    // idle gaps stand for a slow pipeline
    task automatic fire(input logic [6:0] s, input int gap);
        repeat (gap) tick();
        {warm_reset, nmi_take, dbg_take, debug_return_instr} = s[6:3];
        {coproc_move_write, cp_re, cache_tag_we} = s[2:0];
        tick();
        {warm_reset, nmi_take, dbg_take, debug_return_instr} = 4'h0;
        {coproc_move_write, cp_re, cache_tag_we} = 3'h0;
    endtask
endmodule // dbgcp0_pipe_model

// file: testbench/test_debug_exception_cp0_regs.sv
// self-checking bench for the debug/error coprocessor registers
`timescale 1ns/1ps
module test_debug_exception_cp0_regs;
    logic mclk;
    logic reset_n;
    logic mode64, warm_reset, nmi_take, dbg_take, in_delay_slot;
    logic debug_return_instr, coproc_move_write, cp_re, cache_tag_we;
    dbgcp0_pkg::dbgcp0_kind_t dbg_kind;
    logic [63:0] exc_pc, branch_pc, cp_wdata, cp_rdata, redirect_pc;
    logic [4:0] cp_wsel, cp_rsel;
    dbgcp0_pkg::dbgcp0_tagin_t cache_tag_in;
    logic redirect_valid, debug_active;
    dbgcp0_pkg::dbgcp0_tagf_t tag_fields;
    dbgcp0_pkg::dbgcp0_stat_t status_bits;
    logic [31:0] seed = 32'hA8EE;
    int failures = 0;
    int compares = 0;

    dbgcp0_regs dbgcp0_regs_i (
        .mclk, .reset_n, .mode64, .warm_reset, .nmi_take, .dbg_take,
        .dbg_kind, .in_delay_slot, .exc_pc, .branch_pc,
        .debug_return_instr, .coproc_move_write, .cp_wsel, .cp_wdata,
        .cp_re, .cp_rsel, .cache_tag_we, .cache_tag_in, .cp_rdata,
        .redirect_valid, .redirect_pc, .debug_active, .tag_fields,
        .status_bits
    );
    dbgcp0_pipe_model dbgcp0_pipe_model_i (
        .mclk, .mode64, .warm_reset, .nmi_take, .dbg_take, .dbg_kind,
        .in_delay_slot, .exc_pc, .branch_pc, .debug_return_instr,
        .coproc_move_write, .cp_wsel, .cp_wdata, .cp_re, .cp_rsel,
        .cache_tag_we, .cache_tag_in
    );

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // free-running 100 ns clock
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [63:0] rnd64();
        return {rnd(), rnd()};
    endfunction

    // 32-bit mode keeps pcs sign-extended from bit 31
    function automatic logic [63:0] exp_pc(input logic [63:0] v);
        return mode64 ? v : {{32{v[31]}}, v[31:0]};
    endfunction

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic go(input logic [6:0] s);
        // at least one idle edge: strobes never drop and rise in one step
        dbgcp0_pipe_model_i.fire(s, 1 + int'(rnd() % 32'h3));
    endtask

    task automatic wr(input logic [4:0] a, input logic [63:0] d);
        dbgcp0_pipe_model_i.cp_wsel = a;
        dbgcp0_pipe_model_i.cp_wdata = d;
        go(7'h04);
    endtask

    // read data stands from the edge that takes the read
    task automatic rchk(input logic [4:0] a, input logic [63:0] exp);
        dbgcp0_pipe_model_i.cp_rsel = a;
        go(7'h02);
        check(cp_rdata, exp);
    endtask

    // raise an exception with fresh pcs; pe is the pc to be kept
    task automatic exc(input logic ds, input logic [6:0] s,
                       output logic [63:0] pe);
        logic [63:0] ex;
        logic [63:0] br;
        ex = rnd64();
        br = rnd64();
        dbgcp0_pipe_model_i.exc_pc = ex;
        dbgcp0_pipe_model_i.branch_pc = br;
        dbgcp0_pipe_model_i.in_delay_slot = ds;
        go(s);
        pe = exp_pc((ds && (|s[6:4])) ? br : ex);
    endtask

    // hang guard, far beyond the few hundred cycles needed
    initial begin
        #2_000_000;
        failures++;
        give_verdict();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [63:0] v;
        logic [63:0] pc;
        reset_n = 1'b0;
        repeat (5) @(posedge mclk);
        v = rnd64();
        dbgcp0_pipe_model_i.exc_pc = v;
        #1 reset_n = 1'b1;
        rchk(5'h1E, v);
        check(64'(status_bits), 64'h5);
        rchk(5'h0C, 64'h0000_0000_0040_0004);
        rchk(5'h1C, 64'h0);
        rchk(5'h1D, 64'h0);
        // scratch, unmapped numbers and the read-only cause register
        for (int i = 0; i < 4; i++) begin
            v = rnd64();
            wr(5'h1F, v);
            rchk(5'h1F, v);
            wr(5'h03, v);
            rchk(5'h03, 64'h0);
            wr(5'h17, v);
            rchk(5'h17, 64'h0);
        end
        // every exception kind, entry, ignored re-entry and return
        for (int k = 0; k < 6; k++) begin
            v = rnd64();
            dbgcp0_pipe_model_i.mode64 = v[0];
            dbgcp0_pipe_model_i.dbg_kind =
                dbgcp0_pkg::dbgcp0_kind_t'(6'h01 << k);
            exc(v[1], 7'h10, pc);
            check(64'(debug_active), 64'h1);
            rchk(5'h18, pc);
            v = {32'h0, v[1], 1'b1, 24'h0, 6'h01 << k};
            rchk(5'h17, v);
            exc(1'b0, 7'h10, v);
            rchk(5'h18, pc);
            if (k[0]) begin
                v = rnd64();
                wr(5'h18, v);
                pc = exp_pc(v);
            end
            go(7'h08);
            check(64'(redirect_valid), 64'h1);
            check(redirect_pc, pc);
            check(64'(debug_active), 64'h0);
        end
        go(7'h08);
        check(64'(redirect_valid), 64'h0);
        // move and debug capture on the same edge
        dbgcp0_pipe_model_i.cp_wsel = 5'h18;
        dbgcp0_pipe_model_i.cp_wdata = rnd64();
        exc(1'b0, 7'h14, pc);
        rchk(5'h18, pc);
        go(7'h08);
        // tag staging by move and by cache op, all way codes
        for (int i = 0; i < 8; i++) begin
            v = rnd64();
            v[63] = i[1];
            v[1] = i[0];
            v[7:6] = i[2:1];
            if (i < 4) begin
                wr(5'h1C, v);
                wr(5'h1D, {v[31:0], v[63:32]});
            end else begin
                dbgcp0_pipe_model_i.cache_tag_in = v;
                dbgcp0_pipe_model_i.cp_wsel = 5'h1C;
                dbgcp0_pipe_model_i.cp_wdata = ~v;
                go(i[0] ? 7'h05 : 7'h01);
            end
            pc = {32'h0, v[31:0] & 32'hFFFF_FFFE};
            rchk(5'h1C, pc);
            pc = {32'h0, v[63:32] & 32'hC000_0000};
            rchk(5'h1D, pc);
            pc = {34'h0, v[31:8], v[62], v[7:6], v[2], v[63], v[1]};
            check(64'(tag_fields), pc);
        end
        // nmi then warm reset, both from a delay slot
        for (int i = 0; i < 2; i++) begin
            v = rnd64();
            dbgcp0_pipe_model_i.mode64 = v[0];
            exc(1'b1, i ? 7'h40 : 7'h20, pc);
            rchk(5'h1E, pc);
            wr(5'h1E, v);
            rchk(5'h1E, exp_pc(v));
        end
        check(64'(status_bits), 64'h7);
        rchk(5'h0C, 64'h0000_0000_0050_0004);
        // cold reset overlapping a warm reset wins
        @(posedge mclk);
        #1;
        reset_n = 1'b0;
        dbgcp0_pipe_model_i.warm_reset = 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        dbgcp0_pipe_model_i.warm_reset = 1'b0;
        reset_n = 1'b1;
        check(64'(status_bits), 64'h5);
        give_verdict();
    end
endmodule // test_debug_exception_cp0_regs
